// ===== include/sac_defines.svh
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

`define SAC_RES_BITS        8
`define SAC_CODE_ZERO       8'h00
`define SAC_CODE_MID        8'h80
`define SAC_CODE_FULL       8'hFF
`define SAC_FRAME_DATA_EDGES 6'h0A
`define SAC_LEAD_ZERO_EDGES 6'h01
`define SAC_PWRUP_CAL_EDGES 6'h10
`define SAC_CAL_START_EDGE  6'h11
`define SAC_CAL_END_EDGE    6'h20
`define SAC_EDGE_CNT_MAX    6'h3F
`define SAC_OFFSET_ZERO     9'h000
`define SAC_ACQ_TIME_NS     275
`define SAC_CLK_PERIOD_NS   8
`define SAC_ACQ_CYCLES      (((`SAC_ACQ_TIME_NS) + (`SAC_CLK_PERIOD_NS) - 1) / (`SAC_CLK_PERIOD_NS))

`endif

// ===== include/sac_pkg.sv
package sac_pkg;

    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_CONVERT,
        SAC_CALIBRATE,
        SAC_ACQUIRE
    } sac_phase_t;

    typedef struct packed {
        logic [7:0] code;
        logic       cal;
    } sac_word_t;

    typedef struct packed {
        logic sdo_out;
        logic sdo_oe;
    } sac_pin_t;

endpackage

// ===== core/sac_core.sv
// How it works
// RULE1: Chip-select falling edge samples the differential input and starts converting.
// RULE2: Inputs isolated while converting; reconnected for acquisition once conversion ends.
// RULE3: Each result is an 8-bit unsigned straight-binary code.
// RULE4: Codes saturate at 00 and FF; half scale gives 80.
// RULE5: A frame runs from chip-select fall to chip-select rise.
// RULE6: Leading 0 at chip-select fall, then another 0, then eight result bits.
// RULE7: After ten serial clocks data output stays low for the frame.
// RULE8: Chip-select rise ends the frame and releases the data output.
// RULE9: Host leaves 275 ns acquisition after conversion before next sample.
// RULE10: First frame after power-up calibrates and holds data output low.
// RULE11: Power-up calibration needs 16 falling edges, else offset stays unchanged.
// RULE12: Offset register clears at power-up and is not reachable serially.
// RULE13: Analog inputs are disconnected during any calibration.
// RULE14: Host keeps chip select high 275 ns after power-up calibration.
// RULE15: Later results are corrected by the stored offset before shifting.
// RULE16: Frames of 32 edges convert first, calibrate from edge 17 to 32.
// RULE17: Frames shorter than 32 edges leave the stored offset unchanged.
// RULE18: Host should calibrate at power-up, recalibrate after drift.
// RULE19: Only power cycling clears the calibration result.
// RULE20: Result bits leave most significant bit first after two zeros.
// RULE21: Host samples each bit between launching and next falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "sac_defines.svh"

module sac_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    logic             push;
    logic             pop;

    assign o_valid = (wr_reg != rd_reg);
    assign o_ready = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) || (wr_reg[AW] == rd_reg[AW]);
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem[rd_reg[AW-1:0]];

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule

module sac_core
    import sac_pkg::*;
#(
    parameter int RES_BITS = `SAC_RES_BITS,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_cs_n,
    input  wire logic                i_sclk,
    input  wire logic [RES_BITS-1:0] i_sample_code,
    input  wire logic                i_sample_valid,
    output logic                     o_sample_ready,
    input  wire logic [RES_BITS-1:0] i_cal_offset_code,
    output logic                     o_sdo_out,
    output logic                     o_sdo_oe,
    output logic                     o_input_connect,
    output logic                     o_sample_strobe,
    output logic                     o_converting,
    output logic                     o_calibrating,
    output logic                     o_cal_done
);
    logic       cs_meta_reg;
    logic       cs_sync_reg;
    logic       cs_prev_reg;
    logic       sclk_meta_reg;
    logic       sclk_sync_reg;
    logic       sclk_prev_reg;
    logic       cs_fall;
    logic       cs_rise;
    logic       sclk_fall;
    logic       frame_reg;
    logic [5:0] edge_reg;
    logic       powered_reg;
    logic       cal_frame_reg;
    logic [8:0] offset_reg;
    logic [8:0] offset_next;
    logic [7:0] shift_reg;
    logic [7:0] corrected;
    sac_phase_t phase_reg;
    sac_word_t  fifo_in;
    sac_word_t  fifo_out;
    logic       fifo_valid;
    logic       fifo_in_ready;
    logic       fifo_pop;

    // Saturating subtraction of the stored offset keeps codes within 00 and FF.
    function automatic logic [7:0] sac_correct(input logic [7:0] raw, input logic [8:0] off);
        logic signed [10:0] sum;
        sum = $signed({3'b000, raw}) - $signed({{2{off[8]}}, off});
        if (sum < $signed({3'b000, `SAC_CODE_ZERO})) begin // RULE4
            sac_correct = `SAC_CODE_ZERO;
        end else if (sum > $signed({3'b000, `SAC_CODE_FULL})) begin
            sac_correct = `SAC_CODE_FULL;
        end else begin
            sac_correct = sum[7:0];
        end
    endfunction

    // Calibration completes on the 16th fall of the power-up frame or the 32nd of a normal one.
    function automatic logic sac_cal_end(input logic [5:0] cnt, input logic pwr_frame);
        sac_cal_end = pwr_frame ? (cnt == `SAC_PWRUP_CAL_EDGES - 6'h01)
                                : (cnt == `SAC_CAL_END_EDGE - 6'h01);
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_meta_reg   <= 1'b1;
            cs_sync_reg   <= 1'b1;
            cs_prev_reg   <= 1'b1;
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
        end else begin
            cs_meta_reg   <= i_cs_n;
            cs_sync_reg   <= cs_meta_reg;
            cs_prev_reg   <= cs_sync_reg;
            sclk_meta_reg <= i_sclk;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg;
        end
    end

    assign cs_fall   = cs_prev_reg && !cs_sync_reg;
    assign cs_rise   = !cs_prev_reg && cs_sync_reg;
    assign sclk_fall = frame_reg && sclk_prev_reg && !sclk_sync_reg;

    // The sample source feeds results through the FIFO; one word is popped per frame, except in the power-up frame.
    assign fifo_in   = '{code: i_sample_code, cal: 1'b0};
    assign fifo_pop  = cs_fall && !cal_frame_reg && powered_reg;

    sac_fifo #(
        .WIDTH($bits(sac_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_n  (i_rst_n),
        .i_data   (fifo_in),
        .i_valid  (i_sample_valid),
        .o_ready  (fifo_in_ready),
        .o_data   (fifo_out),
        .o_valid  (fifo_valid),
        .i_ready  (fifo_pop)
    );

    assign corrected = sac_correct(fifo_valid ? fifo_out.code : `SAC_CODE_MID, offset_reg); // RULE15

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_reg <= 1'b0;
            edge_reg  <= '0;
        end else if (cs_fall) begin // RULE5
            frame_reg <= 1'b1;
            edge_reg  <= '0;
        end else if (cs_rise) begin
            frame_reg <= 1'b0;
        end else if (sclk_fall && edge_reg != `SAC_EDGE_CNT_MAX) begin
            edge_reg <= edge_reg + 6'h01;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            powered_reg   <= 1'b0;
            cal_frame_reg <= 1'b0;
        end else if (cs_fall) begin
            powered_reg   <= 1'b1;
            cal_frame_reg <= !powered_reg; // RULE10
        end else if (cs_rise) begin
            cal_frame_reg <= 1'b0;
        end
    end

    always_comb begin
        offset_next = offset_reg;
        if (sclk_fall && sac_cal_end(edge_reg, cal_frame_reg)) begin // RULE11 RULE16 RULE17
            offset_next = {i_cal_offset_code[7], i_cal_offset_code};
        end
    end

    // Only the asynchronous reset, standing for power-up, clears the offset.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            offset_reg <= `SAC_OFFSET_ZERO; // RULE12 RULE19
        end else begin
            offset_reg <= offset_next;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_reg <= SAC_IDLE;
        end else begin
            case (phase_reg)
                SAC_IDLE, SAC_ACQUIRE: begin
                    if (cs_fall) begin // RULE1
                        phase_reg <= powered_reg ? SAC_CONVERT : SAC_CALIBRATE;
                    end
                end
                SAC_CONVERT: begin
                    if (cs_rise || (sclk_fall && edge_reg == `SAC_FRAME_DATA_EDGES - 6'h01)) begin
                        phase_reg <= SAC_ACQUIRE; // RULE2
                    end else if (sclk_fall && edge_reg == `SAC_CAL_START_EDGE - 6'h01) begin
                        phase_reg <= SAC_CALIBRATE;
                    end
                end
                SAC_CALIBRATE: begin
                    if (cs_rise || (sclk_fall && edge_reg == `SAC_CAL_END_EDGE - 6'h01)) begin
                        phase_reg <= SAC_ACQUIRE;
                    end
                end
                default: phase_reg <= SAC_IDLE;
            endcase
            if (phase_reg == SAC_ACQUIRE && frame_reg && !cal_frame_reg && sclk_fall
                && edge_reg == `SAC_CAL_START_EDGE - 6'h01) begin
                phase_reg <= SAC_CALIBRATE; // RULE16
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_input_connect <= 1'b1;
            o_converting    <= 1'b0;
            o_calibrating   <= 1'b0;
            o_sample_strobe <= 1'b0;
            o_cal_done      <= 1'b0;
            o_sample_ready  <= 1'b0;
        end else begin
            o_converting    <= (phase_reg == SAC_CONVERT);
            o_calibrating   <= (phase_reg == SAC_CALIBRATE);
            o_input_connect <= (phase_reg == SAC_IDLE) || (phase_reg == SAC_ACQUIRE); // RULE2 RULE13
            o_sample_strobe <= cs_fall; // RULE1
            o_cal_done      <= sclk_fall && sac_cal_end(edge_reg, cal_frame_reg); // RULE11 RULE16
            o_sample_ready  <= fifo_in_ready;
        end
    end

    // Data output: two zeros then the corrected code MSB first, then low.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sdo_out <= 1'b0;
            o_sdo_oe  <= 1'b0;
            shift_reg <= `SAC_CODE_ZERO;
        end else if (cs_fall) begin
            o_sdo_out <= 1'b0; // RULE6
            o_sdo_oe  <= 1'b1;
            shift_reg <= powered_reg ? corrected : `SAC_CODE_ZERO; // RULE3 RULE10
        end else if (cs_rise) begin
            o_sdo_out <= 1'b0;
            o_sdo_oe  <= 1'b0; // RULE8
        end else if (sclk_fall) begin
            if (edge_reg >= `SAC_LEAD_ZERO_EDGES
                && edge_reg < `SAC_FRAME_DATA_EDGES - 6'h01 && !cal_frame_reg) begin
                o_sdo_out <= shift_reg[RES_BITS-1]; // RULE20
                shift_reg <= {shift_reg[RES_BITS-2:0], 1'b0};
            end else begin
                o_sdo_out <= 1'b0; // RULE7
            end
        end
    end

    property p_release;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        cs_rise |=> !o_sdo_oe;
    endproperty
    a_release: assert property (p_release) else $error("data output not released"); // RULE8

    property p_drive;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        cs_fall |=> o_sdo_oe && !o_sdo_out;
    endproperty
    a_drive: assert property (p_drive) else $error("leading zero missing"); // RULE6

    property p_tail_low;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        frame_reg && edge_reg > `SAC_FRAME_DATA_EDGES |-> !o_sdo_out;
    endproperty
    a_tail_low: assert property (p_tail_low) else $error("output high after ten clocks"); // RULE7

    property p_cal_low;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        cal_frame_reg |=> !o_sdo_out;
    endproperty
    a_cal_low: assert property (p_cal_low) else $error("output high in power-up frame"); // RULE10

    property p_short_keep;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !(sclk_fall && sac_cal_end(edge_reg, cal_frame_reg)) |=> $stable(offset_reg);
    endproperty
    a_short_keep: assert property (p_short_keep) else $error("offset changed without edge"); // RULE17

    property p_isolate;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        phase_reg == SAC_CALIBRATE |=> !o_input_connect;
    endproperty
    a_isolate: assert property (p_isolate) else $error("inputs connected in calibration"); // RULE13

    property p_conv_iso;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        phase_reg == SAC_CONVERT |=> !o_input_connect && o_converting;
    endproperty
    a_conv_iso: assert property (p_conv_iso) else $error("inputs connected in conversion"); // RULE2

    property p_sample;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        cs_fall |=> o_sample_strobe ##1 !o_sample_strobe;
    endproperty
    a_sample: assert property (p_sample) else $error("sample strobe wrong"); // RULE1

    c_cal_frame: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cal_frame_reg && o_cal_done);
    c_recal: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !cal_frame_reg && o_calibrating ##[1:1000] o_cal_done);
    c_data_one: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_sdo_oe && o_sdo_out);
endmodule

`default_nettype wire

// ===== test/sac_host.sv
`timescale 1ns/1ps
`default_nettype none

module sac_host (
    input  wire logic i_ref_clk,
    input  wire logic i_sdo_out,
    input  wire logic i_sdo_oe,
    output logic      o_cs_n,
    output logic      o_sclk
);
    logic last_bit = 1'b0;

    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
    end

    // A released line shows the inverse of the last driven bit, so a float never reads as data.
    function automatic logic line();
        return (i_sdo_oe === 1'b1) ? i_sdo_out : ~last_bit;
    endfunction

    task automatic half();
        repeat (4) @(negedge i_ref_clk);
    endtask

    // Runs one frame of n falling edges and returns the bit seen before each fall.
    task automatic run_frame(input int n, output logic [39:0] bits);
        bits = '0;
        @(negedge i_ref_clk);
        o_cs_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            half();
            o_sclk = 1'b1;
            half();
            bits[k] = line();
            if (i_sdo_oe === 1'b1) last_bit = i_sdo_out;
            o_sclk = 1'b0;
        end
        half();
        o_cs_n = 1'b1;
        repeat (40) @(negedge i_ref_clk);
    endtask
endmodule

`default_nettype wire

// ===== test/sac_core_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sac_core_bench;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cs_n;
    logic        sclk;
    logic [7:0]  sample_code = 8'h00;
    logic        sample_valid = 1'b0;
    logic [7:0]  cal_offset = 8'h00;
    logic        sample_ready;
    logic        sdo_out;
    logic        sdo_oe;
    logic        input_connect;
    logic        sample_strobe;
    logic        converting;
    logic        calibrating;
    logic        cal_done;
    logic [39:0] bits;
    int          bad_count = 0;
    int          num_checks = 0;
    int          q[$];
    int          offs = 0;
    int          strobe_cnt = 0;
    int          done_cnt = 0;
    int          conv_cnt = 0;
    int          cal_cnt = 0;

    always #4 ref_clk = ~ref_clk;

    // Counts cycles of the status outputs, sampled where they are settled.
    always @(negedge ref_clk) begin
        if (sample_strobe === 1'b1) strobe_cnt++;
        if (cal_done === 1'b1) done_cnt++;
        if (converting === 1'b1) conv_cnt++;
        if (calibrating === 1'b1) cal_cnt++;
    end

    sac_core dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_sample_code(sample_code), .i_sample_valid(sample_valid),
        .o_sample_ready(sample_ready), .i_cal_offset_code(cal_offset), .o_sdo_out(sdo_out),
        .o_sdo_oe(sdo_oe), .o_input_connect(input_connect), .o_sample_strobe(sample_strobe),
        .o_converting(converting), .o_calibrating(calibrating), .o_cal_done(cal_done));

    sac_host u_host (.i_ref_clk(ref_clk), .i_sdo_out(sdo_out), .i_sdo_oe(sdo_oe),
        .o_cs_n(cs_n), .o_sclk(sclk));

    task automatic summarize();
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] corr(input int c);
        int v;
        v = c - offs;
        return (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : v[7:0];
    endfunction

    task automatic push(input logic [7:0] c);
        @(negedge ref_clk);
        sample_code = c;
        sample_valid = 1'b1;
        @(negedge ref_clk);
        sample_valid = 1'b0;
        q.push_back(c);
        @(negedge ref_clk);
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        q.delete();
        offs = 0;
        repeat (3) @(negedge ref_clk);
        chk_flag(sdo_oe, 1'b0);
        chk_flag(input_connect, 1'b1);
    endtask

    // One frame; a power-up frame must read all zeros, others the corrected code.
    // An empty result queue reads as the mid code.
    task automatic frame(input int n, input logic pwr);
        logic [7:0] exp;
        logic [7:0] got;
        int         s0;
        int         d0;
        int         v0;
        int         c0;
        exp = pwr ? 8'h00 : corr((q.size() > 0) ? q.pop_front() : 128);
        s0 = strobe_cnt;
        d0 = done_cnt;
        v0 = conv_cnt;
        c0 = cal_cnt;
        u_host.run_frame(n, bits);
        for (int i = 0; i < 8; i++) begin
            got[7 - i] = bits[2 + i];
        end
        if (pwr) chk_flag(|bits, 1'b0);
        else chk_code(got, exp);
        chk_code(8'(strobe_cnt - s0), 8'h01);
        chk_code(8'(done_cnt - d0), (pwr ? n >= 16 : n >= 32) ? 8'h01 : 8'h00);
        chk_flag(conv_cnt != v0, !pwr);
        chk_flag(cal_cnt != c0, pwr || n >= 17);
        chk_code({6'h00, bits[1:0]}, 8'h00);
        chk_flag(|bits[39:10], 1'b0);
        chk_flag(sdo_oe, 1'b0);
        chk_flag(input_connect, 1'b1);
        if (pwr ? (n >= 16) : (n >= 32)) offs = int'($signed(cal_offset));
    endtask

    initial begin
        void'($urandom(32'h272E));
        do_reset();
        cal_offset = 8'h05;
        frame(10, 1'b1);
        push(8'h80);
        frame(16, 1'b0);
        cal_offset = 8'hFD;
        push(8'h00);
        frame(32, 1'b0);
        push(8'hFF);
        frame(12, 1'b0);
        push(8'h7E);
        frame(33, 1'b0);
        for (int i = 0; i < 12; i++) begin
            if (sample_ready === 1'b1) push(8'($urandom_range(0, 255)));
        end
        chk_code(8'(q.size()), 8'h08);
        chk_flag(sample_ready, 1'b0);
        for (int i = 0; i < 8; i++) begin
            cal_offset = 8'($urandom_range(0, 15)) - 8'h08;
            frame(10 + $urandom_range(0, 30), 1'b0);
        end
        frame(10, 1'b0);
        do_reset();
        frame(8, 1'b1);
        push(8'h40);
        frame(10, 1'b0);
        do_reset();
        cal_offset = 8'h07;
        frame(16, 1'b1);
        push(8'h03);
        frame(10, 1'b0);
        summarize();
    end

    initial begin
        #500000;
        bad_count++;
        summarize();
    end
endmodule

`default_nettype wire
